// ---- design/cgr_pkg.sv ----
package cgr_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_SYS_ON = 32'h0FFFFC00;
  localparam logic [31:0] ADDR_SYS_OFF = 32'h0FFFFC04;
  localparam logic [31:0] ADDR_SYS_STATE = 32'h0FFFFC08;
  localparam logic [31:0] ADDR_PER_ON = 32'h0FFFFC10;
  localparam logic [31:0] ADDR_PER_OFF = 32'h0FFFFC14;
  localparam logic [31:0] ADDR_PER_STATE = 32'h0FFFFC18;
  localparam logic [31:0] ADDR_PHY_CFG = 32'h0FFFFC1C;
  localparam logic [31:0] ADDR_OSC_CFG = 32'h0FFFFC20;
  localparam logic [31:0] ADDR_FREQ = 32'h0FFFFC24;
  localparam logic [31:0] ADDR_PLL_CFG = 32'h0FFFFC28;
  localparam logic [31:0] ADDR_IRQ_ON = 32'h0FFFFC60;
  localparam logic [31:0] ADDR_IRQ_OFF = 32'h0FFFFC64;
  localparam logic [31:0] ADDR_FLAGS = 32'h0FFFFC68;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0FFFFC6C;
  // system clock bit positions
  localparam int BIT_CPU = 0;
  localparam int BIT_DRAM = 2;
  localparam int BIT_USB_HOST = 6;
  localparam int BIT_PROG0 = 8;
  localparam int BIT_PROG1 = 9;
  // flag bit positions
  localparam int BIT_XTAL_STABLE = 0;
  localparam int BIT_PLL_LOCK = 1;
  localparam int BIT_MCK_READY = 3;
  localparam int BIT_PHY_LOCK = 6;
  // phy pll register fields
  localparam int BIT_PHY_PLL_ON = 16;
  localparam int POS_PHY_PLL_CNT = 20;
  localparam int BIT_PHY_BIAS_ON = 24;
  localparam int POS_PHY_BIAS_CNT = 28;
  // oscillator register fields
  localparam int BIT_XTAL_ON = 0;
  localparam int BIT_XTAL_BYPASS = 1;
  localparam int POS_XTAL_CNT = 8;
  // frequency register fields
  localparam int BIT_FREQ_VALID = 16;
  // pll register fields
  localparam int POS_PLL_DIV = 0;
  localparam int POS_PLL_LOCK_CNT = 8;
  localparam int POS_PLL_RANGE = 14;
  localparam int POS_PLL_MUL = 16;
  // write masks of the read/write registers
  localparam logic [31:0] PHY_CFG_WMASK = 32'hF0F10000 | 32'h01000000;
  localparam logic [31:0] OSC_CFG_WMASK = 32'h0000FF03;
  localparam logic [31:0] PLL_CFG_WMASK = 32'h20FFFFFF;
  localparam logic [31:0] IRQ_WMASK = 32'h00000043;
  // peripheral identifiers that exist (bits 0 and 1 never do)
  localparam logic [31:0] PER_IMPL_MASK = 32'hFFFFFFFC;
  // values after reset
  localparam logic [4:0] SYS_RESET = 5'h01;
  localparam logic [31:0] PHY_CFG_RESET = 32'h10200800;
  localparam logic [31:0] OSC_CFG_RESET = 32'h00000000;
  localparam logic [31:0] PLL_CFG_RESET = 32'h00003F00;
  // counting constants
  localparam int SLOW_MULT_SHIFT = 3;
  localparam logic [4:0] FREQ_WINDOW = 5'h10;
endpackage

// ---- design/cgr_regs.sv ----
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
// How it works
// RL1: prog clock disable write stops output
// RL2: status bits 0, 2 show cpu, dram
// RL3: status bit 6 shows usb host clocks
// RL4: status bits 8, 9 show prog outputs
// RL5: peripheral enable ones switch clocks on
// RL6: unimplemented identifier writes are ignored
// RL7: peripheral disable ones switch clocks off
// RL8: peripheral status shows per-identifier gating
// RL9: phy pll enable starts, lock flag follows
// RL10: phy pll start time is count times 8
// RL11: bias enable, count in slow cycles
// RL12: oscillator enable sets stable after delay
// RL13: bypass sets stable flag at once
// RL14: both bits clear drop stable flag
// RL15: oscillator delay is count times 8
// RL16: measure main cycles over 16 slow periods
// RL17: measurement valid only after oscillator on
// RL18: software writes one into bit 29
// RL19: input divider 0 off, 1 bypass
// RL20: pll lock after lock count slow cycles
// RL21: multiplier zero switches pll off
// RL22: software sets range from pll characteristics
// RL23: flags drive interrupt when enabled
// RL24: gating writes visible on next read
module cgr_regs (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_slow_clk,
  input wire logic i_main_clk,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_cpu_clk_state,
  output logic o_dram_clk_state,
  output logic o_usb_host_clk_state,
  output logic [1:0] o_prog_out_clk,
  output logic [31:0] o_periph_id_bit,
  output logic o_phy_pll_on,
  output logic o_phy_bias_on,
  output logic o_phy_bias_ready,
  output logic o_xtal_osc_on,
  output logic o_xtal_bypass,
  output logic [7:0] o_pll_in_divider,
  output logic [7:0] o_pll_multiplier,
  output logic [1:0] o_pll_freq_range,
  output logic o_pll_active,
  output logic o_irq
);
  import cgr_pkg::*;
  // system clock gates: cpu, dram, usb host, prog0, prog1
  logic cpu_reg, dram_reg, uhost_reg;
  logic [1:0] prog_reg;
  logic [31:0] per_reg;      // peripheral gates
  logic [31:0] phy_cfg_reg;  // phy pll and bias configuration
  logic [31:0] osc_cfg_reg;  // oscillator configuration
  logic [31:0] pll_cfg_reg;  // primary pll configuration
  logic [31:0] irq_mask_reg; // interrupt enables
  // status flags
  logic xtal_stable_flag, pll_locked_flag, phy_pll_locked_flag;
  logic freq_count_valid;
  logic [15:0] main_freq_count;
  // start-up counters and their busy marks
  logic [6:0] phy_cnt_reg;
  logic phy_busy_reg;
  logic [3:0] bias_cnt_reg;
  logic bias_busy_reg;
  logic [10:0] osc_cnt_reg;
  logic osc_busy_reg;
  logic [5:0] pll_cnt_reg;
  logic pll_busy_reg;
  // measurement state
  logic [4:0] win_cnt_reg;
  logic [15:0] edge_cnt_reg;
  // pin synchronisers and edge memories
  logic slow_s1, slow_s2, slow_prev;
  logic main_s1, main_s2, main_prev;
  logic slow_tick, main_edge;
  // decoded write strobes and new register values
  logic wr_sys_on, wr_sys_off, wr_per_on, wr_per_off;
  logic wr_phy, wr_osc, wr_pll, wr_irq_on, wr_irq_off;
  logic [31:0] phy_cfg_next, osc_cfg_next, pll_cfg_next;
  logic [31:0] flags, rd_next;
  logic osc_running;
  // two flops on each pin, edge taken from the second one only
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_prev <= 1'b0;
      main_s1 <= 1'b0;
      main_s2 <= 1'b0;
      main_prev <= 1'b0;
    end else if (i_ce) begin
      slow_s1 <= i_slow_clk;
      slow_s2 <= slow_s1;
      slow_prev <= slow_s2;
      main_s1 <= i_main_clk;
      main_s2 <= main_s1;
      main_prev <= main_s2;
    end
  end
  assign slow_tick = slow_s2 & ~slow_prev;
  assign main_edge = main_s2 & ~main_prev;
  // address decode of writes
  assign wr_sys_on = i_wr && (i_addr == ADDR_SYS_ON);
  assign wr_sys_off = i_wr && (i_addr == ADDR_SYS_OFF);
  assign wr_per_on = i_wr && (i_addr == ADDR_PER_ON);
  assign wr_per_off = i_wr && (i_addr == ADDR_PER_OFF);
  assign wr_phy = i_wr && (i_addr == ADDR_PHY_CFG);
  assign wr_osc = i_wr && (i_addr == ADDR_OSC_CFG);
  assign wr_pll = i_wr && (i_addr == ADDR_PLL_CFG);
  assign wr_irq_on = i_wr && (i_addr == ADDR_IRQ_ON);
  assign wr_irq_off = i_wr && (i_addr == ADDR_IRQ_OFF);
  // merged values of the read/write registers, reserved bits kept
  assign phy_cfg_next = (i_wdata & PHY_CFG_WMASK)
                      | (phy_cfg_reg & ~PHY_CFG_WMASK);
  assign osc_cfg_next = (i_wdata & OSC_CFG_WMASK)
                      | (osc_cfg_reg & ~OSC_CFG_WMASK);
  assign pll_cfg_next = (i_wdata & PLL_CFG_WMASK)
                      | (pll_cfg_reg & ~PLL_CFG_WMASK);
  assign osc_running = osc_cfg_reg[BIT_XTAL_ON]
                     | osc_cfg_reg[BIT_XTAL_BYPASS];
  // system clock gates, set and clear through separate addresses
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cpu_reg <= SYS_RESET[0];
      dram_reg <= SYS_RESET[1];
      uhost_reg <= SYS_RESET[2];
      prog_reg <= SYS_RESET[4:3];
    end else if (i_ce) begin
      if (wr_sys_on) begin
        dram_reg <= dram_reg | i_wdata[BIT_DRAM];
        uhost_reg <= uhost_reg | i_wdata[BIT_USB_HOST];
        prog_reg <= prog_reg | i_wdata[BIT_PROG1:BIT_PROG0];
      end else if (wr_sys_off) begin
        // the processor gate can only be cut here, never set: the on write skips it
        cpu_reg <= cpu_reg & ~i_wdata[BIT_CPU];
        dram_reg <= dram_reg & ~i_wdata[BIT_DRAM];
        uhost_reg <= uhost_reg & ~i_wdata[BIT_USB_HOST];
        prog_reg <= prog_reg & ~i_wdata[BIT_PROG1:BIT_PROG0]; // RL1
      end
    end
  end
  // peripheral gates, missing identifiers masked off
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      per_reg <= 32'h00000000;
    end else if (i_ce) begin
      if (wr_per_on) begin
        per_reg <= per_reg | (i_wdata & PER_IMPL_MASK); // RL5 RL6
      end else if (wr_per_off) begin
        per_reg <= per_reg & ~(i_wdata & PER_IMPL_MASK); // RL7 RL6
      end
    end
  end
  // configuration registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phy_cfg_reg <= PHY_CFG_RESET;
      osc_cfg_reg <= OSC_CFG_RESET;
      pll_cfg_reg <= PLL_CFG_RESET;
    end else if (i_ce) begin
      if (wr_phy) begin
        phy_cfg_reg <= phy_cfg_next;
      end
      if (wr_osc) begin
        osc_cfg_reg <= osc_cfg_next;
      end
      if (wr_pll) begin
        // bit 29 is stored as software writes it
        pll_cfg_reg <= pll_cfg_next; // RL18
      end
    end
  end
  // interrupt enable set/clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_mask_reg <= 32'h00000000;
    end else if (i_ce) begin
      if (wr_irq_on) begin
        irq_mask_reg <= irq_mask_reg | (i_wdata & IRQ_WMASK);
      end else if (wr_irq_off) begin
        irq_mask_reg <= irq_mask_reg & ~(i_wdata & IRQ_WMASK);
      end
    end
  end
  // phy pll start-up: count times 8 slow ticks after enable rises
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phy_cnt_reg <= 7'h00;
      phy_busy_reg <= 1'b0;
      phy_pll_locked_flag <= 1'b0;
    end else if (i_ce) begin
      if (wr_phy && !phy_cfg_next[BIT_PHY_PLL_ON]) begin
        // disabled: lock lost at once
        phy_busy_reg <= 1'b0;
        phy_pll_locked_flag <= 1'b0;
      end else if (wr_phy && !phy_cfg_reg[BIT_PHY_PLL_ON]) begin
        phy_cnt_reg <= {phy_cfg_next[POS_PHY_PLL_CNT +: 4],
                        3'h0}; // RL10
        phy_busy_reg <= 1'b1; // RL9
        phy_pll_locked_flag <= 1'b0;
      end else if (phy_busy_reg && slow_tick) begin
        if (phy_cnt_reg == 7'h00) begin
          phy_busy_reg <= 1'b0;
          phy_pll_locked_flag <= 1'b1; // RL9
        end else begin
          phy_cnt_reg <= phy_cnt_reg - 7'h01;
        end
      end
    end
  end
  // bias start-up: count in plain slow ticks
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bias_cnt_reg <= 4'h0;
      bias_busy_reg <= 1'b0;
      o_phy_bias_ready <= 1'b0;
    end else if (i_ce) begin
      if (wr_phy && !phy_cfg_next[BIT_PHY_BIAS_ON]) begin
        bias_busy_reg <= 1'b0;
        o_phy_bias_ready <= 1'b0;
      end else if (wr_phy && !phy_cfg_reg[BIT_PHY_BIAS_ON]) begin
        bias_cnt_reg <= phy_cfg_next[POS_PHY_BIAS_CNT +: 4]; // RL11
        bias_busy_reg <= 1'b1;
        o_phy_bias_ready <= 1'b0;
      end else if (bias_busy_reg && slow_tick) begin
        if (bias_cnt_reg == 4'h0) begin
          bias_busy_reg <= 1'b0;
          o_phy_bias_ready <= 1'b1; // RL11
        end else begin
          bias_cnt_reg <= bias_cnt_reg - 4'h1;
        end
      end
    end
  end
  // oscillator stable flag: bypass sets at once, enable after delay
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_cnt_reg <= 11'h000;
      osc_busy_reg <= 1'b0;
      xtal_stable_flag <= 1'b0;
    end else if (i_ce) begin
      if (wr_osc && osc_cfg_next[BIT_XTAL_BYPASS]) begin
        osc_busy_reg <= 1'b0;
        xtal_stable_flag <= 1'b1; // RL13
      end else if (wr_osc && !osc_cfg_next[BIT_XTAL_ON]) begin
        osc_busy_reg <= 1'b0;
        xtal_stable_flag <= 1'b0; // RL14
      end else if (wr_osc && !osc_cfg_reg[BIT_XTAL_ON]) begin
        osc_cnt_reg <= {osc_cfg_next[POS_XTAL_CNT +: 8], 3'h0}; // RL15
        osc_busy_reg <= 1'b1; // RL12
        xtal_stable_flag <= 1'b0;
      end else if (osc_busy_reg && slow_tick) begin
        if (osc_cnt_reg == 11'h000) begin
          osc_busy_reg <= 1'b0;
          xtal_stable_flag <= 1'b1; // RL12
        end else begin
          osc_cnt_reg <= osc_cnt_reg - 11'h001;
        end
      end
    end
  end
  // pll lock: every write restarts the lock count
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pll_cnt_reg <= 6'h00;
      pll_busy_reg <= 1'b0;
      pll_locked_flag <= 1'b0;
    end else if (i_ce) begin
      if (wr_pll) begin
        pll_cnt_reg <= pll_cfg_next[POS_PLL_LOCK_CNT +: 6]; // RL20
        pll_busy_reg <= 1'b1;
        pll_locked_flag <= 1'b0;
      end else if (pll_busy_reg && slow_tick) begin
        if (pll_cnt_reg == 6'h00) begin
          pll_busy_reg <= 1'b0;
          pll_locked_flag <= 1'b1; // RL20
        end else begin
          pll_cnt_reg <= pll_cnt_reg - 6'h01;
        end
      end
    end
  end
  // main clock measurement over a window of 16 slow periods
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      win_cnt_reg <= 5'h00;
      edge_cnt_reg <= 16'h0000;
      main_freq_count <= 16'h0000;
      freq_count_valid <= 1'b0;
    end else if (i_ce) begin
      if (!osc_running || !xtal_stable_flag) begin
        // oscillator off or not yet stable: restart, not valid
        win_cnt_reg <= 5'h00;
        edge_cnt_reg <= 16'h0000;
        freq_count_valid <= 1'b0; // RL17
      end else if (!freq_count_valid) begin
        if (win_cnt_reg != 5'h00) begin
          edge_cnt_reg <= edge_cnt_reg + {15'h0000, main_edge};
        end
        if (slow_tick) begin
          if (win_cnt_reg == FREQ_WINDOW) begin
            main_freq_count <= edge_cnt_reg
                             + {15'h0000, main_edge}; // RL16
            freq_count_valid <= 1'b1; // RL17
          end else begin
            win_cnt_reg <= win_cnt_reg + 5'h01;
          end
        end
      end
    end
  end
  // status flag word
  always_comb begin
    flags = 32'h00000000;
    flags[BIT_XTAL_STABLE] = xtal_stable_flag;
    flags[BIT_PLL_LOCK] = pll_locked_flag;
    flags[BIT_MCK_READY] = 1'b1;
    flags[BIT_PHY_LOCK] = phy_pll_locked_flag;
  end
  // read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_next = 32'h00000000;
    unique case (i_addr)
      ADDR_SYS_STATE: begin
        rd_next[BIT_CPU] = cpu_reg; // RL2
        rd_next[BIT_DRAM] = dram_reg; // RL2
        rd_next[BIT_USB_HOST] = uhost_reg; // RL3
        rd_next[BIT_PROG1:BIT_PROG0] = prog_reg; // RL4
      end
      ADDR_PER_STATE: rd_next = per_reg; // RL8
      ADDR_PHY_CFG: rd_next = phy_cfg_reg;
      ADDR_OSC_CFG: rd_next = osc_cfg_reg;
      ADDR_FREQ: begin
        rd_next[15:0] = main_freq_count; // RL16
        rd_next[BIT_FREQ_VALID] = freq_count_valid; // RL17
      end
      ADDR_PLL_CFG: rd_next = pll_cfg_reg;
      ADDR_FLAGS: rd_next = flags;
      ADDR_IRQ_MASK: rd_next = irq_mask_reg;
      default: rd_next = 32'h00000000;
    endcase
  end
  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h00000000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rd_next : 32'h00000000; // RL24
    end
  end
  // registered copies of the gates and clock controls
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cpu_clk_state <= SYS_RESET[0];
      o_dram_clk_state <= SYS_RESET[1];
      o_usb_host_clk_state <= SYS_RESET[2];
      o_prog_out_clk <= SYS_RESET[4:3];
      o_periph_id_bit <= 32'h00000000;
      o_phy_pll_on <= PHY_CFG_RESET[BIT_PHY_PLL_ON];
      o_phy_bias_on <= PHY_CFG_RESET[BIT_PHY_BIAS_ON];
      o_xtal_osc_on <= OSC_CFG_RESET[BIT_XTAL_ON];
      o_xtal_bypass <= OSC_CFG_RESET[BIT_XTAL_BYPASS];
      o_pll_in_divider <= PLL_CFG_RESET[POS_PLL_DIV +: 8];
      o_pll_multiplier <= PLL_CFG_RESET[POS_PLL_MUL +: 8];
      o_pll_freq_range <= PLL_CFG_RESET[POS_PLL_RANGE +: 2];
      o_pll_active <= 1'b0;
    end else if (i_ce) begin
      o_cpu_clk_state <= cpu_reg;
      o_dram_clk_state <= dram_reg;
      o_usb_host_clk_state <= uhost_reg;
      o_prog_out_clk <= prog_reg; // RL1
      o_periph_id_bit <= per_reg;
      o_phy_pll_on <= phy_cfg_reg[BIT_PHY_PLL_ON];
      o_phy_bias_on <= phy_cfg_reg[BIT_PHY_BIAS_ON];
      o_xtal_osc_on <= osc_cfg_reg[BIT_XTAL_ON];
      o_xtal_bypass <= osc_cfg_reg[BIT_XTAL_BYPASS];
      o_pll_in_divider <= pll_cfg_reg[POS_PLL_DIV +: 8];
      o_pll_multiplier <= pll_cfg_reg[POS_PLL_MUL +: 8];
      o_pll_freq_range <= pll_cfg_reg[POS_PLL_RANGE +: 2];
      // divider 0 gives no input, multiplier 0 stops the pll
      o_pll_active <= (pll_cfg_reg[POS_PLL_DIV +: 8] != 8'h00)
                   && (pll_cfg_reg[POS_PLL_MUL +: 8] != 8'h00); // RL19 RL21
    end
  end
  // interrupt line from enabled flags
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(flags & irq_mask_reg); // RL23
    end
  end
endmodule

// ---- testbench/cgr_regs_sva.sv ----
`timescale 1ns/1ps
// watches the register port and the gate outputs of the clock unit
module cgr_regs_sva
  import cgr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_cpu_clk_state,
  input wire logic o_dram_clk_state,
  input wire logic o_usb_host_clk_state,
  input wire logic [1:0] o_prog_out_clk,
  input wire logic [31:0] o_periph_id_bit,
  input wire logic o_phy_pll_on,
  input wire logic o_phy_bias_on,
  input wire logic o_xtal_osc_on,
  input wire logic o_xtal_bypass,
  input wire logic [7:0] o_pll_in_divider,
  input wire logic [7:0] o_pll_multiplier,
  input wire logic [1:0] o_pll_freq_range,
  input wire logic o_pll_active
);
  logic [31:0] w1_reg; // write data one edge back
  logic [31:0] w2_reg; // write data two edges back
  logic [31:0] pm; // implemented part of the written identifiers
  // history of write data, lined up with the output copy flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      w1_reg <= 32'h00000000;
      w2_reg <= 32'h00000000;
    end else begin
      w1_reg <= i_wdata;
      w2_reg <= w1_reg;
    end
  end
  assign pm = w2_reg & PER_IMPL_MASK;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  // a write taken, then one enabled edge for the output copy
  sequence s_wr(logic [31:0] a);
    i_ce && i_wr && i_addr == a ##1 i_ce;
  endsequence
  // a read taken
  sequence s_rd(logic [31:0] a);
    i_ce && i_rd && i_addr == a;
  endsequence
  a_per_on_sets: assert property (s_wr(ADDR_PER_ON) |=>
    (o_periph_id_bit & pm) == pm) else $error("per on missed");
  a_per_off_clears: assert property (s_wr(ADDR_PER_OFF) |=>
    (o_periph_id_bit & pm) == 32'h0) else $error("per off missed");
  a_per_low_zero: assert property (
    o_periph_id_bit[1:0] == 2'h0) else $error("per bits 1:0 set");
  a_sys_on_sets: assert property (s_wr(ADDR_SYS_ON) |=>
    (!w2_reg[2] || o_dram_clk_state) && (!w2_reg[6] || o_usb_host_clk_state)
    && (!w2_reg[8] || o_prog_out_clk[0]) && (!w2_reg[9] || o_prog_out_clk[1]))
    else $error("sys on missed");
  a_sys_off_clears: assert property (s_wr(ADDR_SYS_OFF) |=>
    (!w2_reg[0] || !o_cpu_clk_state) && (!w2_reg[2] || !o_dram_clk_state)
    && (!w2_reg[6] || !o_usb_host_clk_state)
    && (!w2_reg[8] || !o_prog_out_clk[0]) && (!w2_reg[9] || !o_prog_out_clk[1]))
    else $error("sys off missed");
  a_sys_read_map: assert property (s_rd(ADDR_SYS_STATE) |=>
    o_rdata == {22'h0, o_prog_out_clk, 1'b0, o_usb_host_clk_state, 3'h0,
    o_dram_clk_state, 1'b0, o_cpu_clk_state}) else $error("sys read bad");
  a_per_read_map: assert property (s_rd(ADDR_PER_STATE) |=>
    o_rdata == o_periph_id_bit) else $error("per read bad");
  a_osc_cfg_out: assert property (s_wr(ADDR_OSC_CFG) |=>
    o_xtal_osc_on == w2_reg[0] && o_xtal_bypass == w2_reg[1])
    else $error("osc bits bad");
  a_pll_cfg_out: assert property (s_wr(ADDR_PLL_CFG) |=>
    o_pll_in_divider == w2_reg[7:0] && o_pll_multiplier == w2_reg[23:16]
    && o_pll_freq_range == w2_reg[15:14]) else $error("pll fields bad");
  a_phy_cfg_out: assert property (s_wr(ADDR_PHY_CFG) |=>
    o_phy_pll_on == w2_reg[16] && o_phy_bias_on == w2_reg[24])
    else $error("phy bits bad");
  a_pll_active_rel: assert property (
    o_pll_active == (o_pll_in_divider != 8'h00 && o_pll_multiplier != 8'h00))
    else $error("pll active bad");
endmodule
bind cgr_regs cgr_regs_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_cpu_clk_state(o_cpu_clk_state),
  .o_dram_clk_state(o_dram_clk_state),
  .o_usb_host_clk_state(o_usb_host_clk_state),
  .o_prog_out_clk(o_prog_out_clk), .o_periph_id_bit(o_periph_id_bit),
  .o_phy_pll_on(o_phy_pll_on), .o_phy_bias_on(o_phy_bias_on),
  .o_xtal_osc_on(o_xtal_osc_on), .o_xtal_bypass(o_xtal_bypass),
  .o_pll_in_divider(o_pll_in_divider), .o_pll_multiplier(o_pll_multiplier),
  .o_pll_freq_range(o_pll_freq_range), .o_pll_active(o_pll_active));

// ---- testbench/cgr_regs_tb.sv ----
`timescale 1ns/1ps
// register-level bench of the clock unit
module cgr_regs_tb;
  import cgr_pkg::*;
  logic i_clk, i_rst_b, i_ce, i_slow_clk, i_main_clk, i_wr, i_rd;
  logic [31:0] i_addr, i_wdata, o_rdata, o_periph_id_bit, rd_v;
  logic o_cpu_clk_state, o_dram_clk_state, o_usb_host_clk_state;
  logic [1:0] o_prog_out_clk, o_pll_freq_range;
  logic o_phy_pll_on, o_phy_bias_on, o_phy_bias_ready, o_xtal_osc_on;
  logic o_xtal_bypass, o_pll_active, o_irq;
  logic [7:0] o_pll_in_divider, o_pll_multiplier;
  int failures; // mismatches seen
  int checks; // comparisons made
  cgr_regs dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_slow_clk(i_slow_clk), .i_main_clk(i_main_clk), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_cpu_clk_state(o_cpu_clk_state), .o_dram_clk_state(o_dram_clk_state),
    .o_usb_host_clk_state(o_usb_host_clk_state),
    .o_prog_out_clk(o_prog_out_clk), .o_periph_id_bit(o_periph_id_bit),
    .o_phy_pll_on(o_phy_pll_on), .o_phy_bias_on(o_phy_bias_on),
    .o_phy_bias_ready(o_phy_bias_ready), .o_xtal_osc_on(o_xtal_osc_on),
    .o_xtal_bypass(o_xtal_bypass), .o_pll_in_divider(o_pll_in_divider),
    .o_pll_multiplier(o_pll_multiplier), .o_pll_freq_range(o_pll_freq_range),
    .o_pll_active(o_pll_active), .o_irq(o_irq));
  // system clock, 10 ns
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // slow clock, ten system cycles a period
  initial begin
    i_slow_clk = 1'b0;
    forever #50 i_slow_clk = ~i_slow_clk;
  end
  // main clock, 20 MHz: 32 edges in 16 slow periods
  initial begin
    i_main_clk = 1'b0;
    forever #25 i_main_clk = ~i_main_clk;
  end
  // compare and count
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(logic [31:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask
  task automatic rd_chk(string name, logic [31:0] a, logic [31:0] exp);
    rd(a);
    check(name, rd_v, exp);
  endtask
  // bit b of register a is still low after n - 1 slow periods, then rises in time
  task automatic wait_bit(string name, logic [31:0] a, int b, int n);
    int k;
    k = 0;
    repeat ((n - 1) * 10) @(posedge i_clk);
    rd(a);
    check(name, {31'h0, rd_v[b]}, 32'h0);
    while (rd_v[b] !== 1'b1 && k < 100) begin
      rd(a);
      k++;
    end
    check(name, {31'h0, rd_v[b]}, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the tests need about 600 cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
  // main sequence
  initial begin
    failures = 0;
    checks = 0;
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 32'h00000000;
    i_wdata = 32'h00000000;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd_chk("sys_rst", ADDR_SYS_STATE, 32'h00000001);
    rd_chk("per_rst", ADDR_PER_STATE, 32'h00000000);
    rd_chk("phy_rst", ADDR_PHY_CFG, 32'h10200800);
    rd_chk("osc_rst", ADDR_OSC_CFG, 32'h00000000);
    rd_chk("pll_rst", ADDR_PLL_CFG, 32'h00003F00);
    rd_chk("freq_rst", ADDR_FREQ, 32'h00000000);
    rd_chk("unmapped", 32'h0FFFFC0C, 32'h00000000);
    $display("test reset values done");
    wr(ADDR_SYS_ON, 32'hFFFFFFFF);
    rd_chk("sys_on", ADDR_SYS_STATE, 32'h00000345);
    wr(ADDR_SYS_OFF, 32'h00000101);
    wr(ADDR_SYS_STATE, 32'h00000000);
    rd_chk("sys_off", ADDR_SYS_STATE, 32'h00000244);
    check("prog_pins", {30'h0, o_prog_out_clk}, 32'h2);
    wr(ADDR_SYS_OFF, 32'h00000344);
    wr(ADDR_SYS_ON, 32'h00000000);
    rd_chk("sys_all_off", ADDR_SYS_STATE, 32'h00000000);
    check("dram_pin", {31'h0, o_dram_clk_state}, 32'h0);
    $display("test system gates done");
    wr(ADDR_PER_ON, 32'hFFFFFFFF);
    rd_chk("per_on", ADDR_PER_STATE, 32'hFFFFFFFC);
    wr(ADDR_PER_OFF, 32'h00000013);
    wr(ADDR_PER_STATE, 32'h00000000);
    rd_chk("per_off", ADDR_PER_STATE, 32'hFFFFFFEC);
    check("per_pins", o_periph_id_bit, 32'hFFFFFFEC);
    wr(ADDR_PER_OFF, 32'hFFFFFFFF);
    rd_chk("per_all_off", ADDR_PER_STATE, 32'h00000000);
    $display("test peripheral gates done");
    wr(ADDR_IRQ_ON, 32'h00000001);
    rd_chk("irq_mask", ADDR_IRQ_MASK, 32'h00000001);
    wr(ADDR_OSC_CFG, 32'h00000002);
    rd(ADDR_FLAGS);
    check("bypass_stable", {31'h0, rd_v[0]}, 32'h1);
    check("irq_on", {31'h0, o_irq}, 32'h1);
    wr(ADDR_OSC_CFG, 32'h00000000);
    rd(ADDR_FLAGS);
    check("stable_clear", {31'h0, rd_v[0]}, 32'h0);
    check("irq_off", {31'h0, o_irq}, 32'h0);
    wr(ADDR_IRQ_OFF, 32'h00000001);
    $display("test bypass done");
    wr(ADDR_OSC_CFG, 32'h00000201);
    wait_bit("xtal_stable", ADDR_FLAGS, 0, 16);
    check("xtal_pin", {31'h0, o_xtal_osc_on}, 32'h1);
    wait_bit("freq_valid", ADDR_FREQ, 16, 16);
    check("freq_count", {31'h0, rd_v[15:0] >= 16'h001F &&
      rd_v[15:0] <= 16'h0021}, 32'h1);
    wr(ADDR_OSC_CFG, 32'h00000000);
    rd(ADDR_FREQ);
    check("freq_off", {31'h0, rd_v[16]}, 32'h0);
    $display("test oscillator done");
    wr(ADDR_PLL_CFG, 32'h2005C302);
    wait_bit("pll_lock", ADDR_FLAGS, 1, 3);
    check("pll_div", {24'h0, o_pll_in_divider}, 32'h2);
    check("pll_mul", {24'h0, o_pll_multiplier}, 32'h5);
    check("pll_rng", {30'h0, o_pll_freq_range}, 32'h3);
    check("pll_on", {31'h0, o_pll_active}, 32'h1);
    rd_chk("pll_cfg", ADDR_PLL_CFG, 32'h2005C302);
    // long lock count, so no slow tick can relock before the read
    wr(ADDR_PLL_CFG, 32'h20003F01);
    rd(ADDR_FLAGS);
    check("lock_drop", {31'h0, rd_v[1]}, 32'h0);
    check("mul_zero", {31'h0, o_pll_active}, 32'h0);
    wr(ADDR_PLL_CFG, 32'h20050000);
    rd(ADDR_PLL_CFG);
    check("div_zero", {31'h0, o_pll_active}, 32'h0);
    $display("test pll done");
    wr(ADDR_PHY_CFG, 32'h21110000);
    rd_chk("phy_cfg", ADDR_PHY_CFG, 32'h21110800);
    wait_bit("phy_lock", ADDR_FLAGS, 6, 8);
    check("bias_rdy", {31'h0, o_phy_bias_ready}, 32'h1);
    check("phy_pins", {30'h0, o_phy_pll_on, o_phy_bias_on}, 32'h3);
    $display("test phy pll done");
    report_and_stop();
  end
endmodule
